// ### verilog/nvw_pkg.sv
package nvw_pkg;

    // ------------------------------------------------------------
    // Register offsets (choice of this block)
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_CONTROL   = 3'h0;
    localparam logic [2:0] OFF_UNLOCK    = 3'h1;
    localparam logic [2:0] OFF_ADDR_LOW  = 3'h2;
    localparam logic [2:0] OFF_ADDR_HIGH = 3'h3;
    localparam logic [2:0] OFF_DATA_LOW  = 3'h4;
    localparam logic [2:0] OFF_DATA_HIGH = 3'h5;
    localparam logic [2:0] OFF_IRQ_EN    = 3'h6;
    localparam logic [2:0] OFF_IRQ_FLAG  = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTL_SPACE_BIT = 7;
    localparam int CTL_ABORT_BIT = 3;
    localparam int CTL_GATE_BIT  = 2;
    localparam int CTL_WR_BIT    = 1;
    localparam int CTL_RD_BIT    = 0;
    localparam int IRQ_DONE_BIT  = 7;

    localparam logic [7:0] ADDR_HIGH_MASK = 8'h0f;
    localparam logic [7:0] DATA_HIGH_MASK = 8'h3f;
    localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND  = 8'haa;
    localparam logic [7:0] RESET_BYTE     = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ        = 40_000_000;
    localparam int WRITE_TIME_NS = 5000;
    localparam int WRITE_CYCLES  = (WRITE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W         = 8;

    // ------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------
    localparam int DATA_DEPTH = 256;
    localparam int PROG_DEPTH = 16;

    typedef enum logic [2:0] {
        NVW_IDLE  = 3'b001,
        NVW_KEY1  = 3'b010,
        NVW_ARMED = 3'b100
    } nvw_unlock_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } nvw_bus_req_t;

    typedef struct packed {
        logic       req;
        logic       is_write;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvw_mem_req_t;

endpackage

// ### verilog/nvw_store.sv
module nvw_store (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire nvw_pkg::nvw_mem_req_t mreq,
    output logic [7:0]                rdata
);
    // ------------------------------------------------------------
    // Data memory cells, flip-flops indexed by address
    // ------------------------------------------------------------
    logic [7:0] cell_reg [nvw_pkg::DATA_DEPTH];

    genvar gi;
    generate
        for (gi = 0; gi < nvw_pkg::DATA_DEPTH; gi++) begin : g_cell
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cell_reg[gi] <= nvw_pkg::RESET_BYTE;
                end else if (mreq.req && mreq.is_write && mreq.addr == 8'(gi)) begin
                    cell_reg[gi] <= mreq.wdata;
                end
            end
        end
    endgenerate

    assign rdata = cell_reg[mreq.addr];
endmodule

// ### verilog/nvw_ctrl.sv
// Added by the designer: the register addresses and the address-and-strobe port.
module nvw_ctrl (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire nvw_pkg::nvw_bus_req_t bus,
    output logic [7:0]                rdata,
    output logic [11:0]               prog_addr,
    output logic                      prog_fetch,
    input  wire logic [13:0]          prog_word,
    output logic                      slot_skip,
    output logic                      done_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                      space;
        logic                      abort;
        logic                      gate;
        logic                      wr;
        logic                      rd;
        logic [7:0]                addr_lo;
        logic [7:0]                addr_hi;
        logic [7:0]                data_lo;
        logic [7:0]                data_hi;
        logic [7:0]                irq_en;
        logic [7:0]                irq_flag;
        nvw_pkg::nvw_unlock_t      unlock;
        logic [nvw_pkg::CNT_W-1:0] wcnt;
        logic                      pend;
        logic                      fetch;
        logic                      skip;
        logic                      irq;
        logic [7:0]                rdata;
    } nvw_state_t;

    nvw_state_t          st_reg;
    nvw_state_t          st_next;
    logic [7:0]          mem_rdata;
    nvw_pkg::nvw_mem_req_t mreq;

    nvw_store u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .mreq  (mreq),
        .rdata (mem_rdata)
    );

    always_comb begin
        logic [7:0] ctl;
        logic       rd_now;
        ctl    = {st_reg.space, 3'h0, st_reg.abort, st_reg.gate, st_reg.wr, st_reg.rd};
        rd_now = 1'b0;
        st_next = st_reg;
        st_next.fetch = 1'b0;
        st_next.skip  = 1'b0;
        mreq = '0;

        // --------------------------------------------------------
        // Register writes
        // --------------------------------------------------------
        if (bus.wr) begin
            case (bus.addr)
                nvw_pkg::OFF_CONTROL: begin
                    st_next.space = bus.wdata[nvw_pkg::CTL_SPACE_BIT];
                    st_next.abort = bus.wdata[nvw_pkg::CTL_ABORT_BIT];
                    st_next.gate  = bus.wdata[nvw_pkg::CTL_GATE_BIT];
                    // Strobe only taken on the first control write after both keys, with no read between
                    if (bus.wdata[nvw_pkg::CTL_WR_BIT] && !st_reg.wr &&
                        bus.wdata[nvw_pkg::CTL_GATE_BIT] &&
                        !bus.wdata[nvw_pkg::CTL_SPACE_BIT] &&
                        st_reg.unlock == nvw_pkg::NVW_ARMED) begin
                        st_next.wr   = 1'b1;
                        st_next.wcnt = nvw_pkg::CNT_W'(nvw_pkg::WRITE_CYCLES);
                    end
                    if (bus.wdata[nvw_pkg::CTL_RD_BIT] && !st_reg.wr) begin
                        rd_now = 1'b1;
                    end
                    st_next.unlock = nvw_pkg::NVW_IDLE;
                end
                nvw_pkg::OFF_UNLOCK: begin
                    if (bus.wdata == nvw_pkg::UNLOCK_FIRST) begin
                        st_next.unlock = nvw_pkg::NVW_KEY1;
                    end else if (bus.wdata == nvw_pkg::UNLOCK_SECOND &&
                                 st_reg.unlock == nvw_pkg::NVW_KEY1) begin
                        st_next.unlock = nvw_pkg::NVW_ARMED;
                    end else begin
                        st_next.unlock = nvw_pkg::NVW_IDLE;
                    end
                end
                nvw_pkg::OFF_ADDR_LOW:  st_next.addr_lo = bus.wdata;
                nvw_pkg::OFF_ADDR_HIGH: st_next.addr_hi = bus.wdata & nvw_pkg::ADDR_HIGH_MASK;
                nvw_pkg::OFF_DATA_LOW:  st_next.data_lo = bus.wdata;
                nvw_pkg::OFF_DATA_HIGH: st_next.data_hi = bus.wdata & nvw_pkg::DATA_HIGH_MASK;
                nvw_pkg::OFF_IRQ_EN:    st_next.irq_en  = bus.wdata;
                nvw_pkg::OFF_IRQ_FLAG:  st_next.irq_flag = bus.wdata;
                default: begin
                end
            endcase
        end else if (bus.rd) begin
            // A read between keys breaks the sequence, as does a control write; writes to the other registers do not
            st_next.unlock = nvw_pkg::NVW_IDLE;
        end

        // --------------------------------------------------------
        // Reads of the memories
        // --------------------------------------------------------
        if (rd_now) begin
            if (bus.wdata[nvw_pkg::CTL_SPACE_BIT]) begin
                st_next.fetch = 1'b1;
                st_next.rd    = 1'b1;
            end else begin
                mreq.addr       = st_next.addr_lo;
                st_next.data_lo = mem_rdata;
            end
        end
        if (st_reg.fetch) begin
            st_next.data_lo = prog_word[7:0];
            st_next.data_hi = {2'h0, prog_word[13:8]};
            st_next.rd      = 1'b0;
            st_next.skip    = 1'b1;
        end

        // --------------------------------------------------------
        // Write cycle, address and data taken from the registers at count end; gate changes do not matter
        // --------------------------------------------------------
        if (st_reg.wr) begin
            if (st_reg.wcnt == '0) begin
                mreq.req      = 1'b1;
                mreq.is_write = 1'b1;
                mreq.addr     = st_reg.addr_lo;
                mreq.wdata    = st_reg.data_lo;
                st_next.wr    = 1'b0;
                st_next.irq_flag[nvw_pkg::IRQ_DONE_BIT] = 1'b1;
                st_next.abort = 1'b0;
            end else begin
                st_next.wcnt = st_reg.wcnt - 1'b1;
            end
        end

        st_next.irq = |(st_next.irq_flag & st_next.irq_en);

        // --------------------------------------------------------
        // Read data, one cycle later
        // --------------------------------------------------------
        st_next.rdata = '0;
        if (bus.rd) begin
            case (bus.addr)
                nvw_pkg::OFF_CONTROL:   st_next.rdata = ctl;
                nvw_pkg::OFF_UNLOCK:    st_next.rdata = '0;
                nvw_pkg::OFF_ADDR_LOW:  st_next.rdata = st_reg.addr_lo;
                nvw_pkg::OFF_ADDR_HIGH: st_next.rdata = st_reg.addr_hi;
                nvw_pkg::OFF_DATA_LOW:  st_next.rdata = st_reg.data_lo;
                nvw_pkg::OFF_DATA_HIGH: st_next.rdata = st_reg.data_hi;
                nvw_pkg::OFF_IRQ_EN:    st_next.rdata = st_reg.irq_en;
                nvw_pkg::OFF_IRQ_FLAG:  st_next.rdata = st_reg.irq_flag;
                default:                st_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg        <= '0;
            st_reg.unlock <= nvw_pkg::NVW_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rdata      = st_reg.rdata;
    assign prog_addr  = {st_reg.addr_hi[3:0], st_reg.addr_lo};
    assign prog_fetch = st_reg.fetch;
    assign slot_skip  = st_reg.skip;
    assign done_irq   = st_reg.irq;
endmodule

// ### sim/nvw_ctrl_properties.sv
module nvw_ctrl_properties (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire nvw_pkg::nvw_bus_req_t bus,
    input wire logic [7:0]            rdata,
    input wire logic [11:0]           prog_addr,
    input wire logic                  prog_fetch,
    input wire logic [13:0]           prog_word,
    input wire logic                  slot_skip,
    input wire logic                  done_irq
);
    // ------------------------------------------------------------
    // Decoded bus events
    // ------------------------------------------------------------
    logic ctl_rd;
    logic key_wr;
    logic commit;
    assign ctl_rd = bus.rd && bus.addr == nvw_pkg::OFF_CONTROL;
    assign key_wr = bus.wr && bus.addr == nvw_pkg::OFF_UNLOCK;
    assign commit = bus.wr && bus.addr == nvw_pkg::OFF_CONTROL && bus.wdata[nvw_pkg::CTL_WR_BIT];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Strobe known clear first, so a later clear read means refusal
    sequence s_idle;
        ctl_rd ##1 !rdata[nvw_pkg::CTL_WR_BIT];
    endsequence
    sequence s_gate_off;
        key_wr ##1 key_wr ##1 (commit && !bus.wdata[nvw_pkg::CTL_GATE_BIT]);
    endsequence
    sequence s_prog_space;
        key_wr ##1 key_wr ##1 (commit && bus.wdata[nvw_pkg::CTL_SPACE_BIT]);
    endsequence
    sequence s_bad_keys;
        (key_wr && bus.wdata != nvw_pkg::UNLOCK_FIRST) ##1 key_wr ##1 commit;
    endsequence
    sequence s_good;
        (key_wr && bus.wdata == nvw_pkg::UNLOCK_FIRST)
        ##1 (key_wr && bus.wdata == nvw_pkg::UNLOCK_SECOND)
        ##1 (commit && bus.wdata[nvw_pkg::CTL_GATE_BIT] && !bus.wdata[nvw_pkg::CTL_SPACE_BIT]);
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_gate_refuse: assert property (s_idle ##1 s_gate_off ##1 ctl_rd |=> !rdata[1])
        else $error("commit strobe set with gate clear");
    a_space_refuse: assert property (s_idle ##1 s_prog_space ##1 ctl_rd |=> !rdata[1])
        else $error("commit strobe set with program space");
    a_key_order: assert property (s_idle ##1 s_bad_keys ##1 ctl_rd |=> !rdata[1])
        else $error("write began without proper keys");
    a_commit_start: assert property (s_idle ##1 s_good ##1 ctl_rd |=> rdata[1])
        else $error("unlocked commit did not start");
    a_fetch_cause: assert property (prog_fetch |-> $past(bus.wr) && $past(bus.wdata[0]))
        else $error("program fetch without a read request");
    a_skip_follows: assert property (prog_fetch |=> slot_skip && !prog_fetch)
        else $error("slot skip did not follow fetch");
    a_fetch_pulse: assert property (slot_skip |-> $past(prog_fetch) && !prog_fetch)
        else $error("fetch pulse malformed");
    a_unlock_zero: assert property (bus.rd && bus.addr == nvw_pkg::OFF_UNLOCK |=> rdata == 8'h00)
        else $error("unlock port read not zero");
    a_done_held: assert property ($fell(done_irq) |-> $past(bus.wr) && $past(bus.addr[2:1]) == 2'h3)
        else $error("done flag dropped without software");
endmodule

// ### sim/nvw_ctrl_tb.sv
module nvw_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  clk        = 1'b0;
    logic                  rst_b      = 1'b0;
    nvw_pkg::nvw_bus_req_t bus        = '0;
    logic [7:0]            rdata;
    logic [11:0]           prog_addr;
    logic                  prog_fetch;
    logic [13:0]           prog_word;
    logic                  slot_skip;
    logic                  done_irq;
    int                    fail_count = 0;
    int                    n_checks   = 0;
    int                    cycles     = 0;
    always #12.5 clk = ~clk;
    // Stand-in program memory: every address bit shows in the word
    assign prog_word = {prog_addr[11:6], prog_addr[7:0] ^ 8'h3c};
    nvw_ctrl dut (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .prog_addr(prog_addr),
        .prog_fetch(prog_fetch), .prog_word(prog_word), .slot_skip(slot_skip),
        .done_irq(done_irq));
    // ------------------------------------------------------------
    // Bus and check helpers
    // ------------------------------------------------------------
    task chk(input logic [13:0] got, input logic [13:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Driven on the edge; the request stands until the next edge samples it
    task op(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        bus <= '{wr: w, rd: r, addr: a, wdata: d};
        @(posedge clk);
    endtask
    task idle;
        bus <= '0;
        @(posedge clk);
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        op(1'b0, 1'b1, a, 8'h00);
        bus <= '0;
        @(negedge clk);
        chk({6'h00, rdata}, {6'h00, e});
        @(posedge clk);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset_vals;
        for (int a = 1; a < 8; a++) rd(3'(a), 8'h00);
    endtask
    task t_write;
        int i;
        wr(nvw_pkg::OFF_ADDR_LOW, 8'h3c);
        wr(nvw_pkg::OFF_DATA_LOW, 8'ha5);
        wr(nvw_pkg::OFF_IRQ_EN, 8'h80);
        wr(nvw_pkg::OFF_CONTROL, 8'h04);
        rd(nvw_pkg::OFF_CONTROL, 8'h04);
        wr(nvw_pkg::OFF_UNLOCK, nvw_pkg::UNLOCK_FIRST);
        wr(nvw_pkg::OFF_UNLOCK, nvw_pkg::UNLOCK_SECOND);
        wr(nvw_pkg::OFF_CONTROL, 8'h06);
        rd(nvw_pkg::OFF_CONTROL, 8'h06);
        wr(nvw_pkg::OFF_CONTROL, 8'h00);
        rd(nvw_pkg::OFF_CONTROL, 8'h02);
        for (i = 0; i < 400 && done_irq !== 1'b1; i++) @(negedge clk);
        chk({13'h0, done_irq}, 14'h1);
        @(posedge clk);
        rd(nvw_pkg::OFF_CONTROL, 8'h00);
        rd(nvw_pkg::OFF_IRQ_FLAG, 8'h80);
        wr(nvw_pkg::OFF_DATA_LOW, 8'h00);
        wr(nvw_pkg::OFF_CONTROL, 8'h01);
        rd(nvw_pkg::OFF_DATA_LOW, 8'ha5);
        rd(nvw_pkg::OFF_CONTROL, 8'h00);
        wr(nvw_pkg::OFF_IRQ_FLAG, 8'h00);
        idle;
        @(negedge clk);
        chk({13'h0, done_irq}, 14'h0);
        @(posedge clk);
    endtask
    // Gate clear, program space, wrong key order: none may start a write
    task t_refused;
        logic [7:0] k1 [3];
        logic [7:0] k2 [3];
        logic [7:0] c [3];
        k1 = '{8'h55, 8'h55, 8'haa};
        k2 = '{8'haa, 8'haa, 8'h55};
        c = '{8'h02, 8'h86, 8'h06};
        wr(nvw_pkg::OFF_DATA_LOW, 8'h11);
        for (int i = 0; i < 3; i++) begin
            wr(nvw_pkg::OFF_CONTROL, 8'h00);
            rd(nvw_pkg::OFF_CONTROL, 8'h00);
            wr(nvw_pkg::OFF_UNLOCK, k1[i]);
            wr(nvw_pkg::OFF_UNLOCK, k2[i]);
            wr(nvw_pkg::OFF_CONTROL, c[i]);
            rd(nvw_pkg::OFF_CONTROL, c[i] & 8'hfd);
        end
        wr(nvw_pkg::OFF_CONTROL, 8'h00);
        idle;
        repeat (nvw_pkg::WRITE_CYCLES + 4) @(posedge clk);
        rd(nvw_pkg::OFF_IRQ_FLAG, 8'h00);
        wr(nvw_pkg::OFF_CONTROL, 8'h01);
        rd(nvw_pkg::OFF_DATA_LOW, 8'ha5);
    endtask
    task t_prog;
        wr(nvw_pkg::OFF_ADDR_HIGH, 8'h0a);
        wr(nvw_pkg::OFF_ADDR_LOW, 8'h5c);
        wr(nvw_pkg::OFF_CONTROL, 8'h81);
        bus <= '0;
        @(negedge clk);
        chk({13'h0, prog_fetch}, 14'h1);
        chk({2'h0, prog_addr}, 14'ha5c);
        @(negedge clk);
        chk({13'h0, slot_skip}, 14'h1);
        @(posedge clk);
        rd(nvw_pkg::OFF_DATA_LOW, 8'h60);
        rd(nvw_pkg::OFF_DATA_HIGH, 8'h29);
        rd(nvw_pkg::OFF_CONTROL, 8'h80);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_vals;
        t_write;
        t_refused;
        t_prog;
        tally_and_finish;
    end
endmodule
bind nvw_ctrl nvw_ctrl_properties u_props (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
    .prog_addr(prog_addr), .prog_fetch(prog_fetch), .prog_word(prog_word),
    .slot_skip(slot_skip), .done_irq(done_irq));
